// ---- hdl/dpwc_pkg.sv ----
// package: constants, register map and types of the wiper command logic
package dpwc_pkg;

  // ==========================================================
  // sizes
  localparam int WIPER_W = 8;                  // 256 positions
  localparam int NUM_CH  = 2;                  // dual channel
  localparam int NUM_RES = 4;                  // {channel, upper} index
  localparam int CNT_W   = 11;

  // ==========================================================
  // values
  localparam logic [WIPER_W-1:0] MIDSCALE  = 8'h80;
  localparam logic [WIPER_W-1:0] FULLSCALE = 8'hff;
  localparam logic [WIPER_W-1:0] ZEROSCALE = 8'h00;
  localparam logic [WIPER_W-1:0] ONESTEP   = 8'h01;

  // ==========================================================
  // apb register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;   // read only control image
  localparam logic [7:0] OFS_CMD    = 8'h04;   // command launch
  localparam logic [7:0] OFS_DATA   = 8'h08;   // burst data byte
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [3:0] BLK_REGS   = 4'h0;    // paddr[7:4] blocks
  localparam logic [3:0] BLK_WIPER  = 4'h1;
  localparam logic [3:0] BLK_INPUT  = 4'h2;
  localparam logic [3:0] BLK_NV     = 4'h3;

  // ==========================================================
  // field positions
  localparam int CMD_OP_LSB  = 12;             // cmd[15:12] opcode
  localparam int CMD_ADR_LSB = 8;              // cmd[11:8] address
  localparam int ADR_ALL     = 3;              // all channels
  localparam int ADR_UPPER   = 2;              // upper string select
  localparam int ADR_CH      = 0;              // channel select
  localparam int CTRL_PROT   = 0;              // wiper_protect_or_lsb_bit
  localparam int CTRL_NVEN   = 1;              // memory_program_enable_bit
  localparam int CTRL_LIN    = 2;              // linear_mode_bit
  localparam int CTRL_BURST  = 3;              // burst_enable_bit
  localparam logic [3:0] CTRL_RESET = 4'h3;

  // ==========================================================
  // timing
  localparam int RELOAD_NS  = 30000;           // nv reload, 30 us
  localparam int CLK_NS     = 20;
  localparam logic [CNT_W-1:0] RELOAD_CYC =
    CNT_W'((RELOAD_NS + CLK_NS - 1) / CLK_NS);

  // ==========================================================
  // types
  typedef enum logic [3:0] {
    OP_NOP     = 4'h0, OP_WR_WIPER = 4'h1, OP_WR_INPUT = 4'h2,
    OP_WR_CTRL = 4'h3, OP_INC      = 4'h4, OP_DEC      = 4'h5,
    OP_UP6     = 4'h6, OP_DN6      = 4'h7, OP_LOAD_IN  = 4'h8,
    OP_TO_NV   = 4'h9, OP_FROM_NV  = 4'ha, OP_WR_NV    = 4'hb,
    OP_TOP     = 4'hc, OP_BOTTOM   = 4'hd, OP_SWRST    = 4'he,
    OP_SHDN    = 4'hf
  } dpwc_op_t;

  typedef enum logic [2:0] {
    SW_CODE = 3'h0, SW_AB = 3'h1, SW_TOPRES = 3'h2, SW_BOTRES = 3'h3, SW_HIZ = 3'h4
  } dpwc_sw_sel_t;

  typedef enum logic [1:0] {
    SC_NONE = 2'h0, SC_TOP = 2'h1, SC_BOT = 2'h2
  } dpwc_scale_t;

  typedef enum logic {PH_RUN = 1'b0, PH_RELOAD = 1'b1} dpwc_phase_t;

  // upper/lower string switch setting of one channel
  typedef struct packed {
    dpwc_sw_sel_t upper;
    dpwc_sw_sel_t lower;
  } dpwc_sw_t;

  typedef struct packed {
    logic [3:0]                             ctrl;
    logic                                   strap;
    logic                                   strap_ok;
    logic [NUM_RES-1:0][WIPER_W-1:0]        wiper;
    logic [NUM_RES-1:0][WIPER_W-1:0]        inreg;
    logic [NUM_RES-1:0][WIPER_W-1:0]        nv;
    logic [NUM_CH-1:0]                      shut;
    dpwc_scale_t [NUM_CH-1:0]               scale;
    dpwc_phase_t                            phase;
    logic [CNT_W-1:0]                       rl_cnt;
    logic [15:0]                            last_cmd;
    logic                                   last_ok;
    logic                                   pready;
    logic                                   pslverr;
    logic [31:0]                            prdata;
    dpwc_sw_t [NUM_CH-1:0]                  sw;
    logic [NUM_RES-1:0][WIPER_W-1:0]        code;
    logic                                   lin;
    logic                                   busy;
  } dpwc_state_t;

endpackage

// ---- hdl/dpwc_wiper_cmd.sv ----
// wiper command logic of a dual channel digital potentiometer, apb slave
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module dpwc_wiper_cmd
  import dpwc_pkg::*;
(
  input  wire logic                          pclk,           // apb clock
  input  wire logic                          presetn,        // async reset, low
  input  wire logic                          psel,           // apb select
  input  wire logic                          penable,        // apb access phase
  input  wire logic                          pwrite,         // apb direction
  input  wire logic [7:0]                    paddr,          // apb byte address
  input  wire logic [31:0]                   pwdata,         // apb write data
  output logic      [31:0]                   prdata,         // apb read data
  output logic                               pready,         // apb ready
  output logic                               pslverr,        // unmapped access
  input  wire logic                          mode_strap_pin, // linear mode strap
  input  wire logic                          reset_pin_n,    // reload pin, low
  output logic      [NUM_RES-1:0][WIPER_W-1:0] wiper_code,   // wiper values
  output dpwc_sw_t  [NUM_CH-1:0]             string_sw,      // switch settings
  output logic                               linear_mode,    // effective mode
  output logic                               reload_busy     // nv reload running
);

  // ==========================================================
  // helpers
  // step one wiper value for the stepping opcodes
  function automatic logic [WIPER_W-1:0] step_val(
    input dpwc_op_t op, input logic [WIPER_W-1:0] v);
    logic [WIPER_W-1:0] r;
    r = v;
    case (op)
      OP_INC: begin
        r = (v == FULLSCALE) ? v : v + ONESTEP;
      end
      OP_DEC: begin
        r = (v == ZEROSCALE) ? v : v - ONESTEP;
      end
      OP_UP6: begin
        if (v == ZEROSCALE) begin
          r = ONESTEP;
        end else if (v[WIPER_W-1]) begin
          r = FULLSCALE;
        end else begin
          r = {v[WIPER_W-2:0], 1'b0};
        end
      end
      OP_DN6: begin
        r = {1'b0, v[WIPER_W-1:1]};
      end
      default: begin
        r = v;
      end
    endcase
    return r;
  endfunction

  // resources a command addresses; upper strings only exist in linear mode
  function automatic logic [NUM_RES-1:0] res_mask(
    input logic [3:0] adr, input logic lin);
    logic [NUM_RES-1:0] m;
    m = '0;
    if (adr[ADR_ALL]) begin
      m = lin ? 4'hf : 4'h5;
    end else if (lin || !adr[ADR_UPPER]) begin
      m[{adr[ADR_CH], adr[ADR_UPPER]}] = 1'b1;
    end
    return m;
  endfunction

  // ==========================================================
  // state
  dpwc_state_t s_q;
  dpwc_state_t s_d;

  logic                eff;
  logic                acc;
  logic                wr_done;
  logic                go;
  logic                mapped;
  logic                prot_ok;
  logic                nv_ok;
  logic [15:0]         cmd;
  dpwc_op_t            op;
  logic [3:0]          adr;
  logic [7:0]          dat;
  logic [NUM_RES-1:0]  m;
  logic [NUM_CH-1:0]   cm;
  logic [NUM_CH-1:0]   ld;
  logic [31:0]         rd_val;

  // ==========================================================
  // next state
  always_comb begin
    s_d     = s_q;
    eff     = s_q.strap | s_q.ctrl[CTRL_LIN];
    prot_ok = s_q.ctrl[CTRL_PROT];
    nv_ok   = s_q.ctrl[CTRL_NVEN];
    acc     = psel & penable;
    wr_done = acc & s_q.pready & pwrite;
    ld      = '0;

    // strap caught once, at the first edge after reset release
    if (!s_q.strap_ok) begin
      s_d.strap    = mode_strap_pin;
      s_d.strap_ok = 1'b1;
    end

    // apb read mux, word aligned, 0x00..0x3c mapped
    mapped = (paddr[1:0] == 2'b00) && (paddr[7:6] == 2'b00);
    rd_val = '0;
    case (paddr[7:4])
      BLK_REGS: begin
        case (paddr[3:0])
          OFS_CTRL[3:0]: begin
            rd_val = {28'h0000000, s_q.ctrl};
          end
          OFS_STATUS[3:0]: begin
            rd_val = {22'h000000, s_q.scale, s_q.shut,
                      s_q.ctrl[CTRL_BURST], s_q.strap, eff,
                      s_q.phase == PH_RELOAD};
          end
          default: begin
            rd_val = '0;                        // write only registers
          end
        endcase
      end
      BLK_WIPER: begin
        rd_val = {24'h000000, s_q.wiper[paddr[3:2]]};
      end
      BLK_INPUT: begin
        rd_val = {24'h000000, s_q.inreg[paddr[3:2]]};
      end
      BLK_NV: begin
        rd_val = {24'h000000, s_q.nv[paddr[3:2]]};
      end
      default: begin
        rd_val = '0;
      end
    endcase

    // one wait state: ready follows the first access cycle
    s_d.pready  = acc & ~s_q.pready;
    s_d.pslverr = 1'b0;
    s_d.prdata  = '0;
    if (acc && !s_q.pready) begin
      s_d.pslverr = ~mapped;
      s_d.prdata  = pwrite ? 32'h00000000 : rd_val;
    end

    // command launch; data writes only count inside a burst
    go  = 1'b0;
    cmd = s_q.last_cmd;
    if (wr_done && paddr == OFS_CMD) begin
      go  = 1'b1;
      cmd = pwdata[15:0];
    end else if (wr_done && paddr == OFS_DATA && s_q.ctrl[CTRL_BURST]
                 && s_q.last_ok) begin
      go  = 1'b1;
      cmd = {s_q.last_cmd[15:8], pwdata[7:0]};
    end
    // commands during a reload are dropped
    go  = go & (s_q.phase == PH_RUN);
    op  = dpwc_op_t'(cmd[CMD_OP_LSB +: 4]);
    adr = cmd[CMD_ADR_LSB +: 4];
    dat = cmd[7:0];
    m   = res_mask(adr, eff);
    cm  = adr[ADR_ALL] ? 2'b11 : (adr[ADR_CH] ? 2'b10 : 2'b01);
    if (go) begin
      s_d.last_cmd = cmd;
      s_d.last_ok  = 1'b1;
    end

    // execution; shutdown does not block anything
    if (go) begin
      case (op)
        OP_WR_CTRL: begin
          s_d.ctrl = dat[3:0];
        end
        OP_WR_INPUT: begin
          for (int i = 0; i < NUM_RES; i++) begin
            if (m[i]) s_d.inreg[i] = dat;
          end
        end
        OP_WR_WIPER, OP_INC, OP_DEC, OP_UP6, OP_DN6, OP_LOAD_IN: begin
          for (int i = 0; i < NUM_RES; i++) begin
            if (m[i] && prot_ok) begin
              if (op == OP_WR_WIPER) begin
                s_d.wiper[i] = dat;
              end else if (op == OP_LOAD_IN) begin
                s_d.wiper[i] = s_q.inreg[i];
              end else begin
                s_d.wiper[i] = step_val(op, s_q.wiper[i]);
              end
              s_d.inreg[i] = s_d.wiper[i];
              ld[i/2]      = 1'b1;
            end
          end
        end
        OP_FROM_NV: begin
          // the one wiper command protection lets through; the nv reload also ignores it
          for (int i = 0; i < NUM_RES; i++) begin
            if (m[i]) begin
              s_d.wiper[i] = s_q.nv[i];
              s_d.inreg[i] = s_q.nv[i];
              ld[i/2]      = 1'b1;
            end
          end
        end
        OP_TO_NV: begin
          for (int i = 0; i < NUM_RES; i++) begin
            if (m[i] && nv_ok) s_d.nv[i] = s_q.wiper[i];
          end
        end
        OP_WR_NV: begin
          if (nv_ok) s_d.nv[{adr[ADR_CH], adr[ADR_UPPER]}] = dat;
        end
        OP_TOP, OP_BOTTOM: begin
          // scale entry leaves the wiper registers alone
          for (int c = 0; c < NUM_CH; c++) begin
            if (cm[c]) begin
              s_d.scale[c] = !dat[0] ? SC_NONE : (op == OP_TOP ? SC_TOP : SC_BOT);
            end
          end
        end
        OP_SHDN: begin
          for (int c = 0; c < NUM_CH; c++) begin
            if (cm[c]) begin
              s_d.shut[c] = dat[0];
              if (dat[0]) s_d.scale[c] = SC_NONE;
            end
          end
        end
        default: begin
          s_d.ctrl = s_d.ctrl;                            // nop, reset below
        end
      endcase
    end

    // any accepted wiper load leaves the scale position
    for (int c = 0; c < NUM_CH; c++) begin
      if (ld[c]) s_d.scale[c] = SC_NONE;
    end

    // nv reload sequencer
    case (s_q.phase)
      PH_RUN: begin
        if (go && op == OP_SWRST) begin
          s_d.phase  = PH_RELOAD;
          s_d.rl_cnt = RELOAD_CYC - 1'b1;
        end
      end
      PH_RELOAD: begin
        if (s_q.rl_cnt == '0) begin
          s_d.phase = PH_RUN;
          s_d.wiper = s_q.nv;
          s_d.inreg = s_q.nv;
          s_d.scale = {NUM_CH{SC_NONE}};
        end else begin
          s_d.rl_cnt = s_q.rl_cnt - 1'b1;
        end
      end
      default: begin
        s_d.phase = PH_RUN;
      end
    endcase

    // reset pin held low restarts the whole reload and control image
    if (!reset_pin_n) begin
      s_d.ctrl    = CTRL_RESET;
      s_d.shut    = '0;
      s_d.scale   = {NUM_CH{SC_NONE}};
      s_d.phase   = PH_RELOAD;
      s_d.rl_cnt  = RELOAD_CYC - 1'b1;
      s_d.last_ok = 1'b0;
    end

    // switch settings: shutdown over scale over plain code
    for (int c = 0; c < NUM_CH; c++) begin
      if (s_q.shut[c]) begin
        s_d.sw[c].upper = SW_HIZ;
        s_d.sw[c].lower = eff ? SW_HIZ : SW_BOTRES;
      end else if (s_q.scale[c] == SC_TOP) begin
        s_d.sw[c].upper = eff ? SW_AB : SW_TOPRES;
        s_d.sw[c].lower = SW_AB;
      end else if (s_q.scale[c] == SC_BOT) begin
        s_d.sw[c].upper = eff ? SW_TOPRES : SW_AB;
        s_d.sw[c].lower = SW_BOTRES;
      end else begin
        s_d.sw[c].upper = SW_CODE;
        s_d.sw[c].lower = SW_CODE;
      end
    end
    s_d.code = s_q.wiper;
    s_d.lin  = eff;
    s_d.busy = (s_q.phase == PH_RELOAD);
  end

  // ==========================================================
  // registers; reset starts the power-up reload from midscale nv
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q          <= '0;
      s_q.ctrl     <= CTRL_RESET;
      s_q.wiper    <= {NUM_RES{MIDSCALE}};
      s_q.inreg    <= {NUM_RES{MIDSCALE}};
      s_q.nv       <= {NUM_RES{MIDSCALE}};
      s_q.code     <= {NUM_RES{MIDSCALE}};
      s_q.phase    <= PH_RELOAD;
      s_q.rl_cnt   <= RELOAD_CYC - 1'b1;
      s_q.busy     <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state flops
  assign prdata      = s_q.prdata;
  assign pready      = s_q.pready;
  assign pslverr     = s_q.pslverr;
  assign wiper_code  = s_q.code;
  assign string_sw   = s_q.sw;
  assign linear_mode = s_q.lin;
  assign reload_busy = s_q.busy;

endmodule

`default_nettype wire

// ---- verification/dpwc_wiper_cmd_monitor.sv ----
// port checker of the wiper command logic
`timescale 1ns/1ps
`default_nettype none
module dpwc_wiper_cmd_monitor
  import dpwc_pkg::*;
(
  input wire logic                          pclk,           // clock
  input wire logic                          presetn,        // reset, low
  input wire logic                          psel,           // select
  input wire logic                          penable,        // access
  input wire logic                          pwrite,         // direction
  input wire logic [7:0]                    paddr,          // address
  input wire logic [31:0]                   prdata,         // read data
  input wire logic                          pready,         // ready
  input wire logic                          pslverr,        // error
  input wire logic                          mode_strap_pin, // strap
  input wire logic                          reset_pin_n,    // reload pin
  input wire logic [NUM_RES-1:0][WIPER_W-1:0] wiper_code,   // wipers
  input wire dpwc_sw_t [NUM_CH-1:0]         string_sw,      // switches
  input wire logic                          linear_mode,    // mode
  input wire logic                          reload_busy     // reload
);
  // ==========================================================
  // helpers
  logic [10:0] busy_q;  // edges of current reload
  logic [2:0]  cmd_q;   // window after a command write
  logic [2:0]  age_q;   // edges since reset, saturating
  logic        strap_q; // strap as taken at start
  // pin low restarts the count, so only the tail is measured
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= '0;
      cmd_q <= '0;
      age_q <= '0;
      strap_q <= 1'b0;
    end else begin
      busy_q <= (!reload_busy || !reset_pin_n) ? 11'h0 : busy_q + 11'h1;
      if (psel && penable && pready && pwrite && paddr[7:4] == BLK_REGS) begin
        cmd_q <= 3'h4;
      end else if (cmd_q != 3'h0) begin
        cmd_q <= cmd_q - 3'h1;
      end
      if (age_q == 3'h0) begin
        strap_q <= mode_strap_pin;
      end
      if (age_q != 3'h7) begin
        age_q <= age_q + 3'h1;
      end
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // properties
  property p_one_wait;
    psel && $rose(penable) |-> !pready ##1 pready;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("ready wait wrong");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
  property p_unmapped;
    psel && $rose(penable) && paddr[7:6] != 2'h0 |=> pready && pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("no error on hole");
  property p_err_cause;
    pslverr |-> pready && (paddr[7:6] != 2'h0 || paddr[1:0] != 2'h0);
  endproperty
  a_err_cause: assert property (p_err_cause) else $error("stray error");
  property p_strap;
    age_q == 3'h7 && strap_q |-> linear_mode;
  endproperty
  a_strap: assert property (p_strap) else $error("strap mode lost");
  property p_reload_len;
    $fell(reload_busy) |-> busy_q >= 11'h5db && busy_q <= 11'h5df;
  endproperty
  a_reload_len: assert property (p_reload_len) else $error("reload length");
  property p_wiper_quiet;
    !$stable(wiper_code) |-> cmd_q != 3'h0 || $past(reload_busy) || $past(reload_busy, 2);
  endproperty
  a_wiper_quiet: assert property (p_wiper_quiet) else $error("wiper moved");
  property p_top_pot;
    !linear_mode && string_sw[0].upper == SW_TOPRES |-> string_sw[0].lower == SW_AB;
  endproperty
  a_top_pot: assert property (p_top_pot) else $error("top scale wrong");
  property p_shdn;
    string_sw[0].upper == SW_HIZ |-> string_sw[0].lower == (linear_mode ? SW_HIZ : SW_BOTRES);
  endproperty
  a_shdn: assert property (p_shdn) else $error("shutdown wrong");
  c_err: cover property (pready && pslverr);
  c_reload: cover property ($fell(reload_busy));
  c_shdn: cover property (string_sw[0].upper == SW_HIZ);
endmodule
bind dpwc_wiper_cmd dpwc_wiper_cmd_monitor dpwc_wiper_cmd_monitor_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .mode_strap_pin(mode_strap_pin), .reset_pin_n(reset_pin_n), .wiper_code(wiper_code),
  .string_sw(string_sw), .linear_mode(linear_mode), .reload_busy(reload_busy));
`default_nettype wire

// ---- verification/dpwc_apb_host.sv ----
// apb host model that drives the command block
`timescale 1ns/1ps
`default_nettype none
module dpwc_apb_host (
  input  wire logic        pclk,       // bus clock
  output logic             psel,       // select
  output logic             penable,    // access phase
  output logic             pwrite,     // direction
  output logic [7:0]       paddr,      // byte address
  output logic [31:0]      pwdata,     // write data
  input  wire logic [31:0] prdata,     // read data
  input  wire logic        pready,     // ready
  input  wire logic        pslverr,    // error
  output logic             reset_pin_n // reload pin
);
  // ==========================================================
  // idle levels; reload pin held inactive when unused
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    reset_pin_n = 1'b1;
  end
  // one transfer; held until ready is seen at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines must not keep looking valid
    paddr <= ~a;
    pwdata <= ~d;
  endtask
  // short low pulse on the reload pin
  task automatic pulse_rst();
    @(posedge pclk);
    reset_pin_n <= 1'b0;
    repeat (3) @(posedge pclk);
    reset_pin_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench of the wiper command logic
`timescale 1ns/1ps
`default_nettype none
module tb import dpwc_pkg::*;;
  logic pclk, presetn, mode_strap_pin, psel, penable, pwrite, pready, pslverr;
  logic reset_pin_n, linear_mode, reload_busy;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic e;
  logic [NUM_RES-1:0][WIPER_W-1:0] wiper_code;
  dpwc_sw_t [NUM_CH-1:0] string_sw;
  int n_mismatch, tests_run;
  // rows: command, expected wiper 0, expected input 0
  logic [31:0] rows [0:24] = '{
    32'h1000_0000, 32'h6000_0101, 32'h5000_0000, 32'h5000_0000,
    32'h1080_8080, 32'h6000_ffff, 32'h4000_ffff, 32'h7000_7f7f,
    32'h1001_0101, 32'h7000_0000, 32'h7000_0000, 32'h4000_0101,
    32'h2055_0155, 32'h8000_5555, 32'hc001_5555, 32'hf001_5555,
    32'h4000_5656, 32'hf000_5656, 32'h3002_5656, 32'h1011_5656,
    32'h4800_5656, 32'ha000_8080, 32'h3003_8080, 32'h4800_8181,
    32'h7800_4040};
  dpwc_wiper_cmd dpwc_wiper_cmd_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mode_strap_pin(mode_strap_pin),
    .reset_pin_n(reset_pin_n), .wiper_code(wiper_code), .string_sw(string_sw),
    .linear_mode(linear_mode), .reload_busy(reload_busy));
  dpwc_apb_host dpwc_apb_host_inst (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reset_pin_n(reset_pin_n));
  // ==========================================================
  // helpers
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      $display("mismatch %s expected %h seen %h", n, x, g);
      n_mismatch++;
    end
  endtask
  task automatic cmd(input logic [15:0] c);
    dpwc_apb_host_inst.xfer(1'b1, OFS_CMD, {16'h0, c}, q, e);
  endtask
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] x);
    dpwc_apb_host_inst.xfer(1'b0, a, 32'h0, q, e);
    chk(n, x, q);
  endtask
  // outputs lag the accepting edge by one edge
  task automatic sw_chk(input dpwc_sw_t x);
    repeat (3) @(posedge pclk);
    chk("sw0", {26'h0, x}, {26'h0, string_sw[0]});
  endtask
  task automatic idle();
    repeat (3) @(posedge pclk);
    for (int i = 0; i < 4000 && reload_busy !== 1'b0; i++) @(posedge pclk);
    chk("busy", 32'h0, {31'h0, reload_busy});
  endtask
  task automatic end_of_test();
    if (n_mismatch == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // clock and watchdog; the run needs well under 20000 cycles
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    #1000000;
    n_mismatch++;
    end_of_test();
  end
  // ==========================================================
  // main sequence
  initial begin
    presetn = 1'b0;
    mode_strap_pin = 1'b0;
    n_mismatch = 0;
    tests_run = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    idle();
    rd_chk("ctrl", OFS_CTRL, 32'h3);
    rd_chk("nv3", 8'h3c, 32'h80);
    for (int k = 0; k < 25; k++) begin
      cmd(rows[k][31:16]);
      rd_chk("wiper0", 8'h10, {24'h0, rows[k][15:8]});
      rd_chk("input0", 8'h20, {24'h0, rows[k][7:0]});
      chk("code0", {24'h0, rows[k][15:8]}, {24'h0, wiper_code[0]});
    end
    dpwc_apb_host_inst.xfer(1'b0, 8'h40, 32'h0, q, e);
    chk("slverr", 32'h1, {31'h0, e});
    // wiper copy into nv while programming is allowed
    cmd(16'h9000);
    rd_chk("tonv", 8'h30, 32'h40);
    cmd(16'hc001);
    sw_chk({SW_TOPRES, SW_AB});
    cmd(16'hd001);
    sw_chk({SW_AB, SW_BOTRES});
    cmd(16'hf001);
    sw_chk({SW_HIZ, SW_BOTRES});
    cmd(16'hf000);
    sw_chk({SW_CODE, SW_CODE});
    cmd(16'hc001);
    cmd(16'h4000);
    sw_chk({SW_CODE, SW_CODE});
    // scale command with its exit value
    cmd(16'hd001);
    cmd(16'hd000);
    sw_chk({SW_CODE, SW_CODE});
    cmd(16'h3007);
    repeat (3) @(posedge pclk);
    chk("lin", 32'h1, {31'h0, linear_mode});
    cmd(16'h1422);
    rd_chk("upper0", 8'h14, 32'h22);
    rd_chk("lower0", 8'h10, 32'h41);
    cmd(16'hc001);
    sw_chk({SW_AB, SW_AB});
    cmd(16'hd001);
    sw_chk({SW_TOPRES, SW_BOTRES});
    cmd(16'hf001);
    sw_chk({SW_HIZ, SW_HIZ});
    cmd(16'hf000);
    // data writes repeat the last command only while burst is enabled
    cmd(16'h300f);
    cmd(16'h1010);
    dpwc_apb_host_inst.xfer(1'b1, OFS_DATA, 32'h33, q, e);
    rd_chk("burst", 8'h10, 32'h33);
    cmd(16'h3007);
    dpwc_apb_host_inst.xfer(1'b1, OFS_DATA, 32'h44, q, e);
    rd_chk("noburst", 8'h10, 32'h33);
    cmd(16'hb021);
    cmd(16'h3005);
    cmd(16'hb099);
    cmd(16'he000);
    idle();
    rd_chk("swrst", 8'h10, 32'h21);
    dpwc_apb_host_inst.pulse_rst();
    idle();
    rd_chk("pin", 8'h10, 32'h21);
    rd_chk("ctrl2", OFS_CTRL, 32'h3);
    @(posedge pclk);
    presetn <= 1'b0;
    mode_strap_pin <= 1'b1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    idle();
    chk("strap", 32'h1, {31'h0, linear_mode});
    rd_chk("upper1", 8'h1c, 32'h80);
    end_of_test();
  end
endmodule
`default_nettype wire
